// ==== legacy_io_cfg_pkg.sv ====
/*
 * Constants for the legacy I/O resource configuration bank: register
 * indices, function numbers, reset values and field positions.
 * Assumes a 32-bit classic Wishbone slave with a 12-bit byte address.
 */
package legacy_io_cfg_pkg;

    // ------------------------------------------------------------------
    // Address layout: byte address = {function, index, 2'b00}
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 12;
    localparam int IDX_LSB    = 2;
    localparam int IDX_MSB    = 9;
    localparam int FUNC_LSB   = 10;
    localparam int FUNC_MSB   = 11;

    localparam logic [1:0] FUNC_GLOBAL   = 2'h0;
    localparam logic [1:0] FUNC_PARALLEL = 2'h1;
    localparam logic [1:0] FUNC_SERIAL1  = 2'h2;
    localparam logic [1:0] FUNC_SERIAL2  = 2'h3;

    localparam logic [7:0] IDX_GLOBAL_CFG  = 8'h28;
    localparam logic [7:0] IDX_STATUS      = 8'h29;
    localparam logic [7:0] IDX_ACTIVATE    = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH   = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW    = 8'h61;
    localparam logic [7:0] IDX_IRQ_SELECT  = 8'h70;
    localparam logic [7:0] IDX_DMA_SELECT  = 8'h74;
    localparam logic [7:0] IDX_MODE_CONFIG = 8'hf0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_GLOBAL_CFG   = 8'h00;
    localparam logic [7:0] RST_SER1_ACT     = 8'h01;
    localparam logic [7:0] RST_SER2_ACT     = 8'h01;
    localparam logic [7:0] RST_PAR_BASE_HI  = 8'h03;
    localparam logic [7:0] RST_PAR_BASE_LO  = 8'h78;
    localparam logic [7:0] RST_SER1_BASE_HI = 8'h03;
    localparam logic [7:0] RST_SER1_BASE_LO = 8'hf8;
    localparam logic [7:0] RST_SER2_BASE_HI = 8'h02;
    localparam logic [7:0] RST_SER2_BASE_LO = 8'hf8;
    localparam logic [7:0] RST_PAR_IRQ      = 8'h07;
    localparam logic [7:0] RST_SER1_IRQ     = 8'h04;
    localparam logic [7:0] RST_PAR_DMA      = 8'h04;
    localparam logic [7:0] RST_PAR_MODE     = 8'h3f;
    localparam logic [7:0] RST_SER1_CLK     = 8'h00;

    // ------------------------------------------------------------------
    // Fields and decode limits
    // ------------------------------------------------------------------
    localparam int OVERRIDE_BIT = 2;
    localparam int ACTIVE_BIT   = 0;
    localparam int DMA_OFF_BIT  = 2;
    localparam int THRESH_LSB   = 3;
    localparam int THRESH_MSB   = 6;
    localparam logic [7:0] MASK_ACTIVE = 8'h01;
    localparam logic [7:0] MASK_IRQ    = 8'h0f;
    localparam logic [7:0] MASK_DMA    = 8'h07;
    localparam logic [7:0] MASK_MODE   = 8'h7f;
    localparam logic [7:0] MASK_CLK    = 8'h03;
    localparam logic [7:0] MASK_GLOBAL = 8'h04;

    localparam logic [11:0] BASE_MIN   = 12'h100;
    localparam logic [7:0]  BASE_HI_MAX = 8'h0f;
    localparam logic [2:0]  ALIGN4     = 3'h3;
    localparam logic [2:0]  ALIGN8     = 3'h7;

    typedef enum logic [2:0] {
        MODE_SPP      = 3'h0,
        MODE_EPP19    = 3'h1,
        MODE_ECP      = 3'h2,
        MODE_ECP_EPP19 = 3'h3,
        MODE_PRINTER  = 3'h4,
        MODE_EPP17    = 3'h5,
        MODE_RESERVED = 3'h6,
        MODE_ECP_EPP17 = 3'h7
    } par_mode_t;

endpackage : legacy_io_cfg_pkg

// ==== legacy_io_resource_config_bank.sv ====
/*
 * Resource configuration bank for the parallel port and two serial
 * ports: base addresses, interrupt lines, DMA routing, port mode, FIFO
 * threshold and baud clock source, with decoded enables for the cores.
 * Assumes a classic Wishbone master on clk and a synchronous reset.
 */
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps

module legacy_io_resource_config_bank
(
    input  wire logic        clk,              // 250 MHz clock
    input  wire logic        rst,              // Synchronous reset, active high
    input  wire logic        wb_cyc_i,         // Wishbone cycle
    input  wire logic        wb_stb_i,         // Wishbone strobe
    input  wire logic        wb_we_i,          // Wishbone write enable
    input  wire logic [11:0] wb_adr_i,         // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,         // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,         // Wishbone write data
    output logic      [31:0] wb_dat_o,         // Wishbone read data
    output logic             wb_ack_o,         // Wishbone acknowledge
    output logic      [11:0] parBase,          // Parallel port I/O base
    output logic             parDecodeEn,      // Parallel base legal
    output logic      [3:0]  parIrq,           // Parallel interrupt line
    output logic             parDmaEn,         // Parallel DMA requests routed
    output logic      [1:0]  parDmaChannel,    // Parallel DMA channel
    output logic             parModeValid,     // Mode field in force
    output logic             parSppEn,         // Standard bidirectional mode
    output logic             parPrinterEn,     // Printer-only mode
    output logic             parEppEn,         // EPP cycles allowed
    output logic             parEpp17,         // EPP flavour is 1.7
    output logic             parEcpEn,         // ECP mode
    output logic      [3:0]  parFifoThreshold, // ECP FIFO threshold
    output logic             ser1Active,       // First serial port on
    output logic      [11:0] ser1Base,         // First serial I/O base
    output logic             ser1DecodeEn,     // First serial base legal and on
    output logic      [3:0]  ser1Irq,          // First serial interrupt line
    output logic      [1:0]  ser1ClkSel,       // First serial baud clock code
    output logic             ser2Active,       // Second serial port on
    output logic      [11:0] ser2Base,         // Second serial I/O base
    output logic             ser2DecodeEn      // Second serial base legal and on
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  globalCfg;
        logic [7:0]  parBaseHi;
        logic [7:0]  parBaseLo;
        logic [7:0]  parIrqSel;
        logic [7:0]  parDmaSel;
        logic [7:0]  parModeCfg;
        logic [7:0]  ser1Act;
        logic [7:0]  ser1BaseHi;
        logic [7:0]  ser1BaseLo;
        logic [7:0]  ser1IrqSel;
        logic [7:0]  ser1ClkCfg;
        logic [7:0]  ser2Act;
        logic [7:0]  ser2BaseHi;
        logic [7:0]  ser2BaseLo;
        logic        ack;
        logic [31:0] rdData;
        logic [11:0] parBase;
        logic        parDecodeEn;
        logic [3:0]  parIrq;
        logic        parDmaEn;
        logic [1:0]  parDmaChannel;
        logic        parModeValid;
        logic        parSppEn;
        logic        parPrinterEn;
        logic        parEppEn;
        logic        parEpp17;
        logic        parEcpEn;
        logic [3:0]  parFifoThreshold;
        logic        ser1Active;
        logic [11:0] ser1Base;
        logic        ser1DecodeEn;
        logic [3:0]  ser1Irq;
        logic [1:0]  ser1ClkSel;
        logic        ser2Active;
        logic [11:0] ser2Base;
        logic        ser2DecodeEn;
    } bank_state_t;

    bank_state_t state;
    bank_state_t next_state;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Base is legal when it is 100h or above, fits in 12 bits and has
    // the alignment bits clear.
    function automatic logic baseLegal(input logic [7:0] hi,
                                       input logic [7:0] lo,
                                       input logic [2:0] alignMask);
        logic [11:0] base;
        base = {hi[3:0], lo};
        baseLegal = (hi <= legacy_io_cfg_pkg::BASE_HI_MAX)
                 && (base >= legacy_io_cfg_pkg::BASE_MIN)
                 && ((lo[2:0] & alignMask) == 3'h0);
    endfunction : baseLegal

    function automatic logic [7:0] mergeByte(input logic [7:0] old,
                                             input logic [7:0] wr,
                                             input logic [7:0] mask);
        mergeByte = (old & ~mask) | (wr & mask);
    endfunction : mergeByte

    logic [1:0]  func;
    logic [7:0]  idx;
    logic        access;
    logic        doWrite;
    logic [7:0]  wrByte;
    logic [7:0]  rdByte;
    logic        parLegal4;
    logic        parLegal8;
    logic [2:0]  modeCode;
    logic        override;

    assign func     = wb_adr_i[legacy_io_cfg_pkg::FUNC_MSB:legacy_io_cfg_pkg::FUNC_LSB];
    assign idx      = wb_adr_i[legacy_io_cfg_pkg::IDX_MSB:legacy_io_cfg_pkg::IDX_LSB];
    // A new cycle is answered once; ack drops the cycle after it rises
    assign access   = wb_cyc_i && wb_stb_i && !state.ack;
    assign doWrite  = access && wb_we_i && wb_sel_i[0];
    assign wrByte   = wb_dat_i[7:0];
    assign override = state.globalCfg[legacy_io_cfg_pkg::OVERRIDE_BIT];
    assign modeCode = state.parModeCfg[2:0];
    assign parLegal4 = baseLegal(state.parBaseHi, state.parBaseLo,
                                 legacy_io_cfg_pkg::ALIGN4);
    assign parLegal8 = baseLegal(state.parBaseHi, state.parBaseLo,
                                 legacy_io_cfg_pkg::ALIGN8);

    // ------------------------------------------------------------------
    // Read mux (reserved bits read zero)
    // ------------------------------------------------------------------
    always_comb
    begin
        rdByte = 8'h00;
        unique case (func)
            legacy_io_cfg_pkg::FUNC_GLOBAL:
            begin
                if (idx == legacy_io_cfg_pkg::IDX_GLOBAL_CFG)
                    rdByte = state.globalCfg;
                else if (idx == legacy_io_cfg_pkg::IDX_STATUS)
                    rdByte = {3'h0, state.ser2DecodeEn, state.ser1DecodeEn,
                              parLegal8, state.parEppEn, state.parDecodeEn};
            end
            legacy_io_cfg_pkg::FUNC_PARALLEL:
            begin
                unique case (idx)
                    legacy_io_cfg_pkg::IDX_BASE_HIGH:   rdByte = state.parBaseHi;
                    legacy_io_cfg_pkg::IDX_BASE_LOW:    rdByte = state.parBaseLo;
                    legacy_io_cfg_pkg::IDX_IRQ_SELECT:  rdByte = state.parIrqSel;
                    legacy_io_cfg_pkg::IDX_DMA_SELECT:  rdByte = state.parDmaSel;
                    legacy_io_cfg_pkg::IDX_MODE_CONFIG: rdByte = state.parModeCfg;
                    default:                            rdByte = 8'h00;
                endcase
            end
            legacy_io_cfg_pkg::FUNC_SERIAL1:
            begin
                unique case (idx)
                    legacy_io_cfg_pkg::IDX_ACTIVATE:    rdByte = state.ser1Act;
                    legacy_io_cfg_pkg::IDX_BASE_HIGH:   rdByte = state.ser1BaseHi;
                    legacy_io_cfg_pkg::IDX_BASE_LOW:    rdByte = state.ser1BaseLo;
                    legacy_io_cfg_pkg::IDX_IRQ_SELECT:  rdByte = state.ser1IrqSel;
                    legacy_io_cfg_pkg::IDX_MODE_CONFIG: rdByte = state.ser1ClkCfg;
                    default:                            rdByte = 8'h00;
                endcase
            end
            legacy_io_cfg_pkg::FUNC_SERIAL2:
            begin
                unique case (idx)
                    legacy_io_cfg_pkg::IDX_ACTIVATE:    rdByte = state.ser2Act;
                    legacy_io_cfg_pkg::IDX_BASE_HIGH:   rdByte = state.ser2BaseHi;
                    legacy_io_cfg_pkg::IDX_BASE_LOW:    rdByte = state.ser2BaseLo;
                    default:                            rdByte = 8'h00;
                endcase
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state     = state;
        next_state.ack = access;
        if (access)
            next_state.rdData = {24'h0, rdByte};

        // Register writes (unmapped addresses are acked and ignored)
        if (doWrite)
        begin
            unique case (func)
                legacy_io_cfg_pkg::FUNC_GLOBAL:
                    if (idx == legacy_io_cfg_pkg::IDX_GLOBAL_CFG)
                        next_state.globalCfg = mergeByte(state.globalCfg, wrByte,
                                                         legacy_io_cfg_pkg::MASK_GLOBAL);
                legacy_io_cfg_pkg::FUNC_PARALLEL:
                begin
                    if (idx == legacy_io_cfg_pkg::IDX_BASE_HIGH)
                        next_state.parBaseHi = wrByte;
                    if (idx == legacy_io_cfg_pkg::IDX_BASE_LOW)
                        next_state.parBaseLo = wrByte;
                    if (idx == legacy_io_cfg_pkg::IDX_IRQ_SELECT)
                        next_state.parIrqSel = wrByte & legacy_io_cfg_pkg::MASK_IRQ;
                    if (idx == legacy_io_cfg_pkg::IDX_DMA_SELECT)
                        next_state.parDmaSel = wrByte & legacy_io_cfg_pkg::MASK_DMA;
                    if (idx == legacy_io_cfg_pkg::IDX_MODE_CONFIG)
                        next_state.parModeCfg = wrByte & legacy_io_cfg_pkg::MASK_MODE;
                end
                legacy_io_cfg_pkg::FUNC_SERIAL1:
                begin
                    if (idx == legacy_io_cfg_pkg::IDX_ACTIVATE)
                        next_state.ser1Act = wrByte & legacy_io_cfg_pkg::MASK_ACTIVE;
                    if (idx == legacy_io_cfg_pkg::IDX_BASE_HIGH)
                        next_state.ser1BaseHi = wrByte;
                    if (idx == legacy_io_cfg_pkg::IDX_BASE_LOW)
                        next_state.ser1BaseLo = wrByte;
                    if (idx == legacy_io_cfg_pkg::IDX_IRQ_SELECT)
                        next_state.ser1IrqSel = wrByte & legacy_io_cfg_pkg::MASK_IRQ;
                    if (idx == legacy_io_cfg_pkg::IDX_MODE_CONFIG)
                        next_state.ser1ClkCfg = wrByte & legacy_io_cfg_pkg::MASK_CLK;
                end
                legacy_io_cfg_pkg::FUNC_SERIAL2:
                begin
                    if (idx == legacy_io_cfg_pkg::IDX_ACTIVATE)
                        next_state.ser2Act = wrByte & legacy_io_cfg_pkg::MASK_ACTIVE;
                    if (idx == legacy_io_cfg_pkg::IDX_BASE_HIGH)
                        next_state.ser2BaseHi = wrByte;
                    if (idx == legacy_io_cfg_pkg::IDX_BASE_LOW)
                        next_state.ser2BaseLo = wrByte;
                end
            endcase
        end

        // Decoded outputs follow the stored registers one cycle later
        next_state.parBase     = {state.parBaseHi[3:0], state.parBaseLo};
        next_state.parDecodeEn = parLegal4;
        next_state.parIrq      = state.parIrqSel[3:0];
        next_state.parDmaEn    = !state.parDmaSel[legacy_io_cfg_pkg::DMA_OFF_BIT];
        next_state.parDmaChannel = state.parDmaSel[1:0];
        next_state.parFifoThreshold =
            state.parModeCfg[legacy_io_cfg_pkg::THRESH_MSB:legacy_io_cfg_pkg::THRESH_LSB];

        // Override forces plain SPP; the reserved code also falls back to SPP
        next_state.parModeValid = !override && (modeCode != legacy_io_cfg_pkg::MODE_RESERVED);
        next_state.parSppEn     = 1'b1;
        next_state.parPrinterEn = 1'b0;
        next_state.parEppEn     = 1'b0;
        next_state.parEpp17     = 1'b0;
        next_state.parEcpEn     = 1'b0;
        if (!override)
        begin
            unique case (modeCode)
                legacy_io_cfg_pkg::MODE_SPP:       next_state.parSppEn = 1'b1;
                legacy_io_cfg_pkg::MODE_EPP19:     next_state.parEppEn = 1'b1;
                legacy_io_cfg_pkg::MODE_ECP:
                begin
                    next_state.parSppEn = 1'b0;
                    next_state.parEcpEn = 1'b1;
                end
                legacy_io_cfg_pkg::MODE_ECP_EPP19:
                begin
                    next_state.parEcpEn = 1'b1;
                    next_state.parEppEn = 1'b1;
                end
                legacy_io_cfg_pkg::MODE_PRINTER:
                begin
                    next_state.parSppEn     = 1'b0;
                    next_state.parPrinterEn = 1'b1;
                end
                legacy_io_cfg_pkg::MODE_EPP17:
                begin
                    next_state.parEppEn = 1'b1;
                    next_state.parEpp17 = 1'b1;
                end
                legacy_io_cfg_pkg::MODE_RESERVED:  next_state.parSppEn = 1'b1;
                legacy_io_cfg_pkg::MODE_ECP_EPP17:
                begin
                    next_state.parEcpEn = 1'b1;
                    next_state.parEppEn = 1'b1;
                    next_state.parEpp17 = 1'b1;
                end
            endcase
        end
        // EPP needs an 8-byte aligned base; a 4-byte base keeps other modes
        if (!parLegal8)
        begin
            next_state.parEppEn = 1'b0;
            next_state.parEpp17 = 1'b0;
        end

        next_state.ser1Active   = state.ser1Act[legacy_io_cfg_pkg::ACTIVE_BIT];
        next_state.ser1Base     = {state.ser1BaseHi[3:0], state.ser1BaseLo};
        next_state.ser1DecodeEn = state.ser1Act[legacy_io_cfg_pkg::ACTIVE_BIT]
            && baseLegal(state.ser1BaseHi, state.ser1BaseLo,
                         legacy_io_cfg_pkg::ALIGN8);
        next_state.ser1Irq      = state.ser1IrqSel[3:0];
        next_state.ser1ClkSel   = state.ser1ClkCfg[1:0];
        next_state.ser2Active   = state.ser2Act[legacy_io_cfg_pkg::ACTIVE_BIT];
        next_state.ser2Base     = {state.ser2BaseHi[3:0], state.ser2BaseLo};
        next_state.ser2DecodeEn = state.ser2Act[legacy_io_cfg_pkg::ACTIVE_BIT]
            && baseLegal(state.ser2BaseHi, state.ser2BaseLo,
                         legacy_io_cfg_pkg::ALIGN8);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state            <= '0;
            state.globalCfg  <= legacy_io_cfg_pkg::RST_GLOBAL_CFG;
            state.parBaseHi  <= legacy_io_cfg_pkg::RST_PAR_BASE_HI;
            state.parBaseLo  <= legacy_io_cfg_pkg::RST_PAR_BASE_LO;
            state.parIrqSel  <= legacy_io_cfg_pkg::RST_PAR_IRQ;
            state.parDmaSel  <= legacy_io_cfg_pkg::RST_PAR_DMA;
            state.parModeCfg <= legacy_io_cfg_pkg::RST_PAR_MODE;
            state.ser1Act    <= legacy_io_cfg_pkg::RST_SER1_ACT;
            state.ser1BaseHi <= legacy_io_cfg_pkg::RST_SER1_BASE_HI;
            state.ser1BaseLo <= legacy_io_cfg_pkg::RST_SER1_BASE_LO;
            state.ser1IrqSel <= legacy_io_cfg_pkg::RST_SER1_IRQ;
            state.ser1ClkCfg <= legacy_io_cfg_pkg::RST_SER1_CLK;
            state.ser2Act    <= legacy_io_cfg_pkg::RST_SER2_ACT;
            state.ser2BaseHi <= legacy_io_cfg_pkg::RST_SER2_BASE_HI;
            state.ser2BaseLo <= legacy_io_cfg_pkg::RST_SER2_BASE_LO;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign wb_dat_o         = state.rdData;
    assign wb_ack_o         = state.ack;
    assign parBase          = state.parBase;
    assign parDecodeEn      = state.parDecodeEn;
    assign parIrq           = state.parIrq;
    assign parDmaEn         = state.parDmaEn;
    assign parDmaChannel    = state.parDmaChannel;
    assign parModeValid     = state.parModeValid;
    assign parSppEn         = state.parSppEn;
    assign parPrinterEn     = state.parPrinterEn;
    assign parEppEn         = state.parEppEn;
    assign parEpp17         = state.parEpp17;
    assign parEcpEn         = state.parEcpEn;
    assign parFifoThreshold = state.parFifoThreshold;
    assign ser1Active       = state.ser1Active;
    assign ser1Base         = state.ser1Base;
    assign ser1DecodeEn     = state.ser1DecodeEn;
    assign ser1Irq          = state.ser1Irq;
    assign ser1ClkSel       = state.ser1ClkSel;
    assign ser2Active       = state.ser2Active;
    assign ser2Base         = state.ser2Base;
    assign ser2DecodeEn     = state.ser2DecodeEn;

endmodule : legacy_io_resource_config_bank

// ==== legacy_io_cfg_asserts.sv ====
/* Checker for the resource configuration bank.
   Sees only the bank's ports; bound to every instance of the bank. */
`timescale 1ns/1ps
module legacy_io_cfg_asserts (
    input wire logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, // Bus
    input wire logic [11:0] wb_adr_i, parBase, ser1Base, // Addresses
    input wire logic [3:0]  wb_sel_i, parFifoThreshold,  // Lanes, threshold
    input wire logic [31:0] wb_dat_i,                    // Write data
    input wire logic [1:0]  ser1ClkSel, parDmaChannel,   // Clock code, channel
    input wire logic        parDecodeEn, parDmaEn, parEppEn, parEcpEn, // Decodes
    input wire logic        parPrinterEn, parModeValid, ser1DecodeEn, ser1Active // Decodes
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Write is seen at the edge sampling ack; decodes land one edge later
    wire wrOk = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    sequence wrTo(a);
        wrOk && wb_adr_i == a;
    endsequence
    chk_dma_route: assert property (wrTo(12'h5d0) |=>
        parDmaEn == !$past(wb_dat_i[2]) && parDmaChannel == $past(wb_dat_i[1:0]))
        else $error("dma decode wrong");
    chk_fifo_thresh: assert property (wrTo(12'h7c0) |=>
        parFifoThreshold == $past(wb_dat_i[6:3])) else $error("threshold wrong");
    chk_ser1_clock: assert property (wrTo(12'hbc0) |=>
        ser1ClkSel == $past(wb_dat_i[1:0])) else $error("clock code wrong");
    chk_ser1_on: assert property (wrTo(12'h8c0) |=>
        ser1Active == $past(wb_dat_i[0])) else $error("activation wrong");
    chk_epp_align: assert property (parEppEn |->
        parDecodeEn && parBase[2:0] == 3'h0) else $error("epp on bad base");
    chk_par_range: assert property (parDecodeEn |->
        parBase >= 12'h100 && parBase[1:0] == 2'h0) else $error("parallel base bad");
    chk_ser1_decode: assert property (ser1DecodeEn |-> ser1Active &&
        ser1Base >= 12'h100 && ser1Base[2:0] == 3'h0) else $error("serial base bad");
    chk_mode_gate: assert property ((parEcpEn || parEppEn || parPrinterEn) |->
        parModeValid) else $error("mode used while gated");
endmodule : legacy_io_cfg_asserts
bind legacy_io_resource_config_bank legacy_io_cfg_asserts chk (.*);

// ==== tb.sv ====
/* Self-checking bench for the resource configuration bank.
   Drives the Wishbone port itself; no far-side model. */
`timescale 1ns/1ps
module tb;
    logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [11:0] wb_adr_i = '0, parBase, ser1Base, ser2Base;
    logic [3:0] wb_sel_i = '0, parIrq, parFifoThreshold, ser1Irq;
    logic [31:0] wb_dat_i = '0, wb_dat_o;
    logic [1:0] parDmaChannel, ser1ClkSel;
    logic parDecodeEn, parDmaEn, parModeValid, parSppEn, parPrinterEn, parEppEn, parEpp17;
    logic parEcpEn, ser1Active, ser1DecodeEn, ser2Active, ser2DecodeEn;
    logic [31:0] q;
    int errors = 0, checks = 0, cycles = 0;
    // Row: address, reset value, written value, value read back
    logic [35:0] rows [13] = '{36'h5c0_07_ff_0f, 36'h5d0_04_0b_03,
        36'h7c0_3f_ff_7f, 36'h8c0_01_fe_00, 36'hcc0_01_ff_01,
        36'h9c0_04_ff_0f, 36'hbc0_00_02_02, 36'h0a0_00_ff_04,
        36'h580_03_0f_0f, 36'h584_78_fc_fc, 36'h980_03_03_03,
        36'hd84_f8_f4_f4, 36'h3f0_00_ff_00};
    // Spp, printer, epp, epp17, ecp, valid for each mode code
    logic [5:0] modeExp [8] = '{6'h21, 6'h29, 6'h03, 6'h2b, 6'h11, 6'h2d, 6'h20, 6'h2f};
    legacy_io_resource_config_bank dut (.*);
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task chk(input string n, input logic [31:0] e, input logic [31:0] v);
        checks++;
        if (v !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, v);
        end
    endtask : chk
    task wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, a};
        {wb_dat_i, wb_sel_i} <= {24'h0, d, 4'h1};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 0;
        foreach (rows[i])
        begin
            wb(0, rows[i][35:24], 8'h00);
            chk("reset value", rows[i][23:16], q);
            wb(1, rows[i][35:24], rows[i][15:8]);
            wb(0, rows[i][35:24], 8'h00);
            chk("readback", rows[i][7:0], q);
        end
        $display("test registers done");
        wb(1, 12'h0a0, 8'h00);
        settle();
        chk("epp at 4-byte base", 0, parEppEn);
        wb(1, 12'h584, 8'hf8);
        settle();
        chk("epp at 8-byte base", 1, parEppEn);
        chk("serial inactive", 0, ser1DecodeEn);
        chk("serial2 4-byte base", 0, ser2DecodeEn);
        chk("parallel irq", 4'hf, parIrq);
        chk("serial1 irq", 4'hf, ser1Irq);
        chk("serial1 base", 12'h3f8, ser1Base);
        chk("serial2 active", 1, ser2Active);
        chk("serial2 base", 12'h2f4, ser2Base);
        wb(0, 12'h0a4, 8'h00);
        chk("status", 8'h07, q);
        wb(1, 12'h580, 8'h00);
        settle();
        chk("base below 100h", 0, parDecodeEn);
        wb(1, 12'h580, 8'h03);
        for (int m = 0; m < 9; m++)
        begin
            wb(1, m[3] ? 12'h0a0 : 12'h7c0, m[3] ? 8'h04 : 8'(m));
            settle();
            chk("mode", m[3] ? 6'h20 : modeExp[m], {parSppEn, parPrinterEn,
                parEppEn, parEpp17, parEcpEn, parModeValid});
        end
        $display("test decodes done");
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        settle();
        chk("base after reset", 12'h378, parBase);
        chk("dma off after reset", 0, parDmaEn);
        chk("threshold after reset", 4'h7, parFifoThreshold);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : tb
